// ===== hdl/ssr_ctrl.sv
// Notes on behaviour
// - in subclock mode, select bit and trigger bit both 1 enter sub-stop
// - sub-stop halts main and subclock oscillators, removing all clocks
// - sub-stop ends on nmi, unmasked pin or peripheral interrupt, or reset pin
// - interrupt wake returns to subclock mode, reset pin to normal mode
// - any unmasked request wakes; lower priority stays pending, unacknowledged
// - higher priority request or nmi wakes and is acknowledged
// - nmi always branches; maskable branches only when interrupts enabled
// - reset pin exit from either sub standby is an ordinary reset
// - sub-idle: rtc runs, cpu and peripherals stop, serial on ext clock, ports held
// - sub-stop: rtc stops too, bus interface unpowered, ports held
// - interrupt controller in both standbys only accepts wake requests
// - cpu registers, status and ram kept across sub-stop
// - two reset sources: reset pin low and watchdog overflow
// - reset pin high releases reset and cpu starts fetching
// - watchdog reset status is 8 bits, byte or bit access
// - status writes need the protect sequence; others discarded, set error flag
// - status cleared to 00 by reset pin, loaded 01 on watchdog reset
// - flag reads 0 when no watchdog reset occurred
// - flag cleared only by writing 0; writing 1 does nothing
// - watchdog reset keeps main oscillator, no stabilization wait
module ssr_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] bit_mask,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic wdt_overflow,
  input wire logic nmi_req,
  input wire logic maskable_req,
  input wire logic [2:0] req_prio,
  input wire logic int_enable,
  input wire logic in_subclock,
  output ssr_pkg::ssr_enables_t enables,
  output ssr_pkg::ssr_wake_t wake,
  output logic cpu_rst
);

  ssr_pkg::ssr_regs_t q;
  ssr_pkg::ssr_regs_t d;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // unit enables for a given power state
  function automatic ssr_pkg::ssr_enables_t enables_for(ssr_pkg::ssr_state_t s);
    ssr_pkg::ssr_enables_t e;
    e = '{main_osc_on: 1'b1, sub_osc_on: 1'b1, cpu_clk_on: 1'b1,
          periph_clk_on: 1'b1, rtc_on: 1'b1, csi_ext_only: 1'b0,
          bus_if_power: 1'b1, port_hold: 1'b0, intc_wake_only: 1'b0};
    unique case (s)
      ssr_pkg::ST_SIDLE: begin
        e.cpu_clk_on = 1'b0;
        e.periph_clk_on = 1'b0;
        e.csi_ext_only = 1'b1;
        e.port_hold = 1'b1;
        e.intc_wake_only = 1'b1;
      end
      ssr_pkg::ST_SSTOP: begin
        e.main_osc_on = 1'b0;
        e.sub_osc_on = 1'b0;
        e.cpu_clk_on = 1'b0;
        e.periph_clk_on = 1'b0;
        e.csi_ext_only = 1'b1;
        // rtc off, bus unpowered, ports held
        e.rtc_on = 1'b0;
        e.bus_if_power = 1'b0;
        e.port_hold = 1'b1;
        e.intc_wake_only = 1'b1;
      end
      default: begin
      end
    endcase
    return e;
  endfunction

  // write a byte or selected bits only
  function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] nv, logic [7:0] m);
    return (old & ~m) | (nv & m);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic wake_any;
    logic higher;
    logic [7:0] nv;
    wake_any = 1'b0;
    higher = 1'b0;
    nv = 8'h00;
    d = q;
    d.wake = '0;
    d.rdata = 8'h00;
    d.cpu_rst = 1'b0;

    // any unmasked request wakes; priority only decides acknowledge and branch
    wake_any = nmi_req | maskable_req;
    // higher priority or nmi is acknowledged
    higher = nmi_req | (maskable_req && (req_prio < q.prio));

    // register writes; key must be the write just before the status write
    if (wr) begin
      d.key_ok = 1'b0;
      unique case (addr)
        ssr_pkg::ADDR_MODE: begin
          nv = merge({7'h00, q.psm}, wdata, bit_mask);
          d.psm = nv[ssr_pkg::BIT_PSM];
        end
        ssr_pkg::ADDR_TRIG: begin
          nv = merge({6'h00, q.stp, 1'b0}, wdata, bit_mask);
          d.stp = nv[ssr_pkg::BIT_STP];
        end
        ssr_pkg::ADDR_PROT: d.key_ok = (wdata == ssr_pkg::PROT_KEY);
        ssr_pkg::ADDR_WDRS: begin
          if (q.key_ok) begin
            nv = merge(q.wdrs, wdata, bit_mask);
            d.wdrs[ssr_pkg::BIT_WATCHDOG_RESET_FLAG] = q.wdrs[ssr_pkg::BIT_WATCHDOG_RESET_FLAG] & nv[ssr_pkg::BIT_WATCHDOG_RESET_FLAG];
          end else begin
            d.prerr = 1'b1;
          end
        end
        ssr_pkg::ADDR_SYS: begin
          if (bit_mask[ssr_pkg::BIT_PRERR] && !wdata[ssr_pkg::BIT_PRERR]) begin
            d.prerr = 1'b0;
          end
        end
        ssr_pkg::ADDR_PRIO: d.prio = wdata[2:0];
        default: begin
        end
      endcase
    end

    // register reads, data next cycle
    if (rd) begin
      unique case (addr)
        ssr_pkg::ADDR_MODE: d.rdata = {7'h00, q.psm};
        ssr_pkg::ADDR_TRIG: d.rdata = {6'h00, q.stp, 1'b0};
        // full byte, flag 0 until watchdog reset
        ssr_pkg::ADDR_WDRS: d.rdata = q.wdrs;
        ssr_pkg::ADDR_SYS: d.rdata = {7'h00, q.prerr};
        ssr_pkg::ADDR_STAT: d.rdata = {3'h0, q.state};
        ssr_pkg::ADDR_PRIO: d.rdata = {5'h00, q.prio};
        default: d.rdata = 8'h00;
      endcase
    end

    // power state machine
    unique case (q.state)
      ssr_pkg::ST_NORMAL: begin
        if (in_subclock) begin
          d.state = ssr_pkg::ST_SUB;
        end
      end
      ssr_pkg::ST_SUB: begin
        if (!in_subclock) begin
          d.state = ssr_pkg::ST_NORMAL;
        end else if (d.stp) begin
          // allow the trailing no-op window before gating
          d.state = ssr_pkg::ST_ENTER;
          d.nop_cnt = ssr_pkg::NOP_CYC;
        end
      end
      ssr_pkg::ST_ENTER: begin
        if (q.nop_cnt != 3'h0) begin
          d.nop_cnt = q.nop_cnt - 3'h1;
        end else begin
          d.stp = 1'b0;
          // select bit picks stop over idle
          d.state = q.psm ? ssr_pkg::ST_SSTOP : ssr_pkg::ST_SIDLE;
        end
      end
      ssr_pkg::ST_SIDLE, ssr_pkg::ST_SSTOP: begin
        if (wake_any) begin
          d.state = ssr_pkg::ST_SUB;
          d.wake.pending = !higher;
          d.wake.ack = higher;
          d.wake.branch = nmi_req | (higher & int_enable);
        end
      end
      default: d.state = ssr_pkg::ST_NORMAL;
    endcase

    d.en = enables_for(d.state);

    if (wdt_overflow) begin
      d.wdrs = ssr_pkg::WDRS_WDT;
      d.state = ssr_pkg::ST_NORMAL;
      d.psm = 1'b0;
      d.stp = 1'b0;
      d.key_ok = 1'b0;
      d.prio = ssr_pkg::PRIO_NONE;
      d.cpu_rst = 1'b1;
      d.wake = '0;
      d.en = enables_for(ssr_pkg::ST_NORMAL);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // pin reset is the ordinary reset and wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{state: ssr_pkg::ST_NORMAL, psm: 1'b0, stp: 1'b0, key_ok: 1'b0,
             prerr: 1'b0, wdrs: ssr_pkg::WDRS_RST, prio: ssr_pkg::PRIO_NONE,
             nop_cnt: 3'h0, rdata: 8'h00, cpu_rst: 1'b1,
             en: '{main_osc_on: 1'b1, sub_osc_on: 1'b1, cpu_clk_on: 1'b1,
                   periph_clk_on: 1'b1, rtc_on: 1'b1, csi_ext_only: 1'b0,
                   bus_if_power: 1'b1, port_hold: 1'b0, intc_wake_only: 1'b0},
             wake: '0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rdata = q.rdata;
  assign enables = q.en;
  assign wake = q.wake;
  assign cpu_rst = q.cpu_rst;

endmodule

// ===== hdl/ssr_pkg.sv
package ssr_pkg;

  // register indices on the plain port
  localparam logic [3:0] ADDR_MODE = 4'h0;  // power_save_select_bit
  localparam logic [3:0] ADDR_TRIG = 4'h1;  // standby_trigger_register
  localparam logic [3:0] ADDR_PROT = 4'h2;  // protect_command_register
  localparam logic [3:0] ADDR_WDRS = 4'h3;  // watchdog_reset_status_reg
  localparam logic [3:0] ADDR_SYS = 4'h4;  // protect_error_flag
  localparam logic [3:0] ADDR_STAT = 4'h5;  // power state, read only
  localparam logic [3:0] ADDR_PRIO = 4'h6;  // in-service priority level

  // field positions and values
  localparam int BIT_PSM = 0;
  localparam int BIT_STP = 1;
  localparam int BIT_WATCHDOG_RESET_FLAG = 0;
  localparam int BIT_PRERR = 0;
  localparam logic [7:0] PROT_KEY = 8'hA5;
  localparam logic [7:0] WDRS_RST = 8'h00;
  localparam logic [7:0] WDRS_WDT = 8'h01;
  localparam logic [2:0] PRIO_NONE = 3'h7;

  // trailing no-op slots software must leave after the trigger write
  localparam int NOP_SLOTS = 5;
  localparam logic [2:0] NOP_CYC = 3'(NOP_SLOTS);

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_SUB = 5'h02,
    ST_SIDLE = 5'h04,
    ST_SSTOP = 5'h08,
    ST_ENTER = 5'h10
  } ssr_state_t;

  // clock and unit enables presented to the rest of the chip
  typedef struct packed {
    logic main_osc_on;
    logic sub_osc_on;
    logic cpu_clk_on;
    logic periph_clk_on;
    logic rtc_on;
    logic csi_ext_only;
    logic bus_if_power;
    logic port_hold;
    logic intc_wake_only;
  } ssr_enables_t;

  // wake-up report
  typedef struct packed {
    logic ack;
    logic branch;
    logic pending;
  } ssr_wake_t;

  typedef struct packed {
    ssr_state_t state;
    logic psm;
    logic stp;
    logic key_ok;
    logic prerr;
    logic [7:0] wdrs;
    logic [2:0] prio;
    logic [2:0] nop_cnt;
    logic [7:0] rdata;
    logic cpu_rst;
    ssr_enables_t en;
    ssr_wake_t wake;
  } ssr_regs_t;

endpackage

// ===== testbench/ssr_monitor.sv
module ssr_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic wdt_overflow,
  input wire logic nmi_req,
  input wire logic in_subclock,
  input wire ssr_pkg::ssr_enables_t enables,
  input wire ssr_pkg::ssr_wake_t wake,
  input wire logic cpu_rst
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // read port and reset behaviour
  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_wdt_rst;
    wdt_overflow |=> cpu_rst;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("no cpu reset");
  property p_fetch;
    $rose(reset_n) && !wdt_overflow |=> !cpu_rst;
  endproperty
  a_fetch: assert property (p_fetch) else $error("cpu held in reset");
  // stop pattern of the enables
  property p_stop_osc;
    !enables.sub_osc_on |-> !enables.main_osc_on && !enables.cpu_clk_on && !enables.periph_clk_on;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("clock left on");
  property p_stop_io;
    !enables.sub_osc_on |-> !enables.rtc_on && !enables.bus_if_power && enables.port_hold;
  endproperty
  a_stop_io: assert property (p_stop_io) else $error("stop io wrong");
  property p_intc;
    !enables.cpu_clk_on |-> enables.intc_wake_only;
  endproperty
  a_intc: assert property (p_intc) else $error("intc not waking");
  // wake reporting
  property p_nmi;
    $rose(nmi_req) && !enables.sub_osc_on && in_subclock |=> wake.ack && wake.branch;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not taken");
  property p_pend;
    wake.pending |-> !wake.ack && !wake.branch;
  endproperty
  a_pend: assert property (p_pend) else $error("pending acked");
  c_stop: cover property (!enables.sub_osc_on);
  c_pend: cover property (wake.pending);
  c_ack: cover property (wake.ack && wake.branch);
endmodule
bind ssr_ctrl ssr_monitor u_mon (.*);

// ===== testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic key;
    logic [3:0] wa;
    logic [7:0] wd;
    logic [7:0] wm;
    logic [3:0] ra;
    logic [7:0] ex;
  } ssr_row_t;
  logic clk, reset_n, wr, rd, wdt_overflow, nmi_req, maskable_req, int_enable, in_subclock;
  logic cpu_rst;
  logic [3:0] addr;
  logic [7:0] wdata, bit_mask, rdata;
  logic [2:0] req_prio;
  ssr_pkg::ssr_enables_t enables;
  ssr_pkg::ssr_wake_t wake;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  ssr_row_t rows [6];
  logic [8:0] wk [3];
  ssr_ctrl DUT (.*);
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bit_mask <= m;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // trigger write, then quiet slots
  task automatic stop;
    wreg(ssr_pkg::ADDR_TRIG, 8'h02, 8'hFF);
    repeat (12) @(posedge clk);
    #1 chk(8'(enables.sub_osc_on), 8'h00);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    rows = '{'{1'b0, ssr_pkg::ADDR_WDRS, 8'h00, 8'hFF, ssr_pkg::ADDR_WDRS, 8'h01},
      '{1'b0, ssr_pkg::ADDR_WDRS, 8'h00, 8'hFF, ssr_pkg::ADDR_SYS, 8'h01},
      '{1'b0, ssr_pkg::ADDR_SYS, 8'h00, 8'h01, ssr_pkg::ADDR_SYS, 8'h00},
      '{1'b1, ssr_pkg::ADDR_WDRS, 8'hFF, 8'h01, ssr_pkg::ADDR_WDRS, 8'h01},
      '{1'b1, ssr_pkg::ADDR_WDRS, 8'h00, 8'h01, ssr_pkg::ADDR_WDRS, 8'h00},
      '{1'b0, 4'hF, 8'hFF, 8'hFF, 4'hF, 8'h00}};
    // nmi, maskable, prio, int enable, ack/branch/pending
    wk = '{9'b0_1_111_1_001, 9'b0_1_000_0_100, 9'b1_0_000_0_110};
    reset_n = 1'b0;
    {wr, rd, wdt_overflow, nmi_req, maskable_req, int_enable, in_subclock} = '0;
    {addr, wdata, bit_mask, req_prio} = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rchk(ssr_pkg::ADDR_WDRS, ssr_pkg::WDRS_RST);
    rchk(ssr_pkg::ADDR_STAT, 8'h01);
    rchk(ssr_pkg::ADDR_PRIO, 8'h07);
    // watchdog overflow
    @(posedge clk) wdt_overflow <= 1'b1;
    @(posedge clk) wdt_overflow <= 1'b0;
    #1 chk(8'(cpu_rst), 8'h01);
    repeat (3) @(posedge clk);
    #1 chk(8'(enables.main_osc_on), 8'h01);
    rchk(ssr_pkg::ADDR_WDRS, ssr_pkg::WDRS_WDT);
    foreach (rows[i]) begin
      if (rows[i].key) wreg(ssr_pkg::ADDR_PROT, ssr_pkg::PROT_KEY, 8'hFF);
      wreg(rows[i].wa, rows[i].wd, rows[i].wm);
      rchk(rows[i].ra, rows[i].ex);
    end
    // wake from sub-stop by each source
    in_subclock <= 1'b1;
    wreg(ssr_pkg::ADDR_MODE, 8'h01, 8'hFF);
    foreach (wk[i]) begin
      stop();
      {nmi_req, maskable_req, req_prio, int_enable} <= wk[i][8:3];
      for (int n = 0; n < 10; n++) begin
        @(posedge clk);
        #1;
        if (wake !== 3'h0) break;
      end
      chk(8'(wake), 8'(wk[i][2:0]));
      @(posedge clk) {nmi_req, maskable_req} <= 2'b00;
      rchk(ssr_pkg::ADDR_STAT, 8'h02);
    end
    // sub-idle entry and nmi wake
    wreg(ssr_pkg::ADDR_MODE, 8'h00, 8'hFF);
    wreg(ssr_pkg::ADDR_TRIG, 8'h02, 8'hFF);
    repeat (12) @(posedge clk);
    #1 chk(8'(enables.rtc_on), 8'h01);
    chk(8'(enables.cpu_clk_on), 8'h00);
    chk(8'(enables.intc_wake_only), 8'h01);
    @(posedge clk) nmi_req <= 1'b1;
    @(posedge clk) #1 chk(8'(wake), 8'h06);
    @(posedge clk) nmi_req <= 1'b0;
    rchk(ssr_pkg::ADDR_STAT, 8'h02);
    wreg(ssr_pkg::ADDR_MODE, 8'h01, 8'hFF);
    // reset pin during sub-stop
    stop();
    reset_n <= 1'b0;
    in_subclock <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rchk(ssr_pkg::ADDR_STAT, 8'h01);
    chk(8'(enables.sub_osc_on), 8'h01);
    // pin reset and overflow together
    @(posedge clk) wdt_overflow <= 1'b1;
    @(posedge clk) reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    {reset_n, wdt_overflow} <= 2'b10;
    rchk(ssr_pkg::ADDR_WDRS, ssr_pkg::WDRS_RST);
    wrap_up();
  end
endmodule
